// File: upfc_pkg.sv
/*
 * Package for the UART pin function control block: register indices,
 * field positions, reset values, mode codes and the carrier structs.
 * Assumes a 10 MHz core clock and an APB register bus.
 */
package upfc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_TX_BREAK = 12'h00a;
    localparam logic [11:0] IDX_TURNAROUND = 12'h00b;
    localparam logic [11:0] IDX_PIN_FUNC = 12'h00c;
    localparam logic [11:0] IDX_PIN_DIR = 12'h00d;
    localparam logic [11:0] IDX_PIN_SET = 12'h00e;
    localparam logic [11:0] IDX_UART_CTRL = 12'h040;
    localparam logic [11:0] IDX_PIN_STATUS = 12'h041;

    localparam logic [15:0] RST_TX_BREAK = 16'h0000;
    localparam logic [3:0] RST_TURNAROUND = 4'h0;
    localparam logic [9:0] RST_PIN_FUNC = 10'h300;
    localparam logic [9:0] RST_PIN_DIR = 10'h000;
    localparam logic [15:0] BREAK_FOREVER = 16'hffff;

    // Field positions in the pin-function register
    localparam int F_RX_TOGGLE = 9;
    localparam int F_TX_TOGGLE = 8;
    localparam int F_CLK_OUT = 7;
    localparam int F_SEC_LO = 5;
    localparam int F_SEC_PIN = 4;
    localparam int F_POLARITY = 3;
    localparam int F_MODE_LO = 0;

    // Pin numbers with alternate functions
    localparam int P_DTR = 2;
    localparam int P_DSR = 3;
    localparam int P_CTS = 4;
    localparam int P_PRIMARY = 5;
    localparam int P_CLK = 6;
    localparam int P_SECONDARY = 7;
    localparam int P_TX_TOG = 8;
    localparam int P_RX_TOG = 9;

    // Timing: one bit time at the default rate, break unit in bit times
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_DEFAULT = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;

    typedef enum logic [2:0] {
        UPFC_MODE_GPIO = 3'b000,
        UPFC_MODE_RTS_CTS = 3'b001,
        UPFC_MODE_DTR_DSR = 3'b010,
        UPFC_MODE_EN_ACT = 3'b011,
        UPFC_MODE_EN_FLOW = 3'b100
    } upfc_mode_e;

    typedef enum logic [1:0] {
        UPFC_SEC_GPIO = 2'b00,
        UPFC_SEC_EN_ACT = 2'b01,
        UPFC_SEC_EN_FLOW = 2'b10
    } upfc_sec_e;

    // Status of the UART engine
    typedef struct packed {
        logic tx_busy;
        logic addr_match;
        logic tx_pulse;
        logic rx_pulse;
        logic rx_ready;
        logic clk_out;
    } upfc_uart_s;

    // Two-signal pin group: output value and output enable
    typedef struct packed {
        logic [9:0] o;
        logic [9:0] oe;
    } upfc_pins_s;
endpackage

// File: upfc_bit_timer.sv
/*
 * Down counter of whole bit times. Loading starts a count of len bit
 * times; done pulses for one cycle when it ends. A len of 0 starts no count and gives no done.
 */
`timescale 1ns/1ps
module upfc_bit_timer #(
    parameter int LEN_W = 16,
    parameter int BIT_CYC = 86
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [LEN_W-1:0] len,
    output logic busy,
    output logic done
);
    // The cycle counter is 16 bits wide
    if (BIT_CYC < 1 || BIT_CYC > 65536 || LEN_W < 1) begin : bad_params
        $error("upfc_bit_timer: bad parameters");
    end
    logic [LEN_W-1:0] bits;
    logic [15:0] cyc;
    logic [LEN_W-1:0] next_bits;
    logic [15:0] next_cyc;
    logic next_busy;
    logic next_done;

    always_comb begin
        next_bits = bits;
        next_cyc = cyc;
        next_busy = busy;
        next_done = 1'b0;
        if (load) begin
            next_bits = len;
            next_cyc = 16'(BIT_CYC - 1);
            next_busy = (len != '0);
        end else if (busy) begin
            if (cyc != 16'h0000) begin
                next_cyc = cyc - 16'h0001;
            end else begin
                next_cyc = 16'(BIT_CYC - 1);
                next_bits = bits - LEN_W'(1);
                if (bits == LEN_W'(1)) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bits <= '0;
            cyc <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            bits <= next_bits;
            cyc <= next_cyc;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule // upfc_bit_timer

// File: upfc_sync2.sv
/*
 * Two-flop synchroniser for a vector of pin inputs. Assumes the pins
 * are asynchronous to ref_clk.
 */
`timescale 1ns/1ps
module upfc_sync2 #(
    parameter int W = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    if (W < 1) begin : bad_width
        $error("upfc_sync2: bad width");
    end
    logic [W-1:0] meta;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // upfc_sync2

// File: upfc_top.sv
/*
 * UART pin function control: break control, RS-485 turn-around delay,
 * pin function selection, pin direction and set-only output register.
 * Assumes an APB master and a UART engine on ref_clk that reports its
 * state through the upfc_uart_s carrier.
 */
// Notes on behaviour
// R1: Break value all ones holds transmit output in break until changed.
// R2: Other non-zero break values give a break of that many bit times.
// R3: Direction enable drops 0-15 bit times after transmission ends.
// R4: Function bit 9 picks pin 9 receive toggle, resets to 1.
// R5: Function bit 8 picks pin 8 transmit toggle, resets to 1.
// R6: Function bit 7 routes clock output to pin 6.
// R7: Secondary field: 00 I/O, 01 enable while sending, 10 on match.
// R8: Pin-select bit enables the secondary field on pin 7; the mode field drives pin 5 enable either way.
// R9: Software keeps pin 5 function different from pin 7 function.
// R10: Polarity bit 0 makes direction enable active low, 1 active high.
// R11: Mode field assigns RTS/CTS, DTR/DSR or enable roles to pins.
// R12: Software avoids reserved mode and secondary codes.
// R13: Direction register sets plain pins input or output only.
// R14: Writing ones to set register drives plain output pins high.
// R15: Set register leaves pins configured as inputs untouched.
// R16: Software writes zero to reserved upper bits.
// R17: Match-only receive mode gates received data on address match.
`timescale 1ns/1ps
module upfc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire upfc_pkg::upfc_uart_s uart,
    input wire logic uart_rts_want,
    input wire logic uart_dtr_want,
    output logic tx_pin,
    output logic tx_hold,
    output logic rx_accept,
    output upfc_pkg::upfc_pins_s pins,
    input wire logic [9:0] pin_in
);
    logic [15:0] tx_break;
    logic [3:0] turnaround;
    logic [9:0] pin_func;
    logic [9:0] pin_dir;
    logic [9:0] pin_out;
    logic [2:0] flow_mode;
    logic [15:0] next_tx_break;
    logic [3:0] next_turnaround;
    logic [9:0] next_pin_func;
    logic [9:0] next_pin_dir;
    logic [9:0] next_pin_out;
    logic [2:0] next_flow_mode;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [9:0] pin_sync;
    logic wr_en;
    logic rd_en;
    logic [11:0] idx;
    logic addr_ok;

    upfc_sync2 #(.W(10)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(pin_in),
        .q(pin_sync)
    );

    // APB: answer in the second access cycle, after one wait state
    assign idx = paddr[13:2];
    assign wr_en = psel && penable && !pready && pwrite;
    assign rd_en = psel && penable && !pready && !pwrite;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00)
        && (idx == upfc_pkg::IDX_TX_BREAK || idx == upfc_pkg::IDX_TURNAROUND
        || idx == upfc_pkg::IDX_PIN_FUNC || idx == upfc_pkg::IDX_PIN_DIR
        || idx == upfc_pkg::IDX_PIN_SET || idx == upfc_pkg::IDX_UART_CTRL
        || idx == upfc_pkg::IDX_PIN_STATUS);

    // Alternate-function mask: a pin is plain when no alternate function owns it
    logic [9:0] alt;
    logic sec_sel;
    always_comb begin
        alt = 10'h000;
        sec_sel = pin_func[upfc_pkg::F_SEC_PIN];
        alt[upfc_pkg::P_RX_TOG] = pin_func[upfc_pkg::F_RX_TOGGLE]; // R4
        alt[upfc_pkg::P_TX_TOG] = pin_func[upfc_pkg::F_TX_TOGGLE]; // R5
        alt[upfc_pkg::P_CLK] = pin_func[upfc_pkg::F_CLK_OUT]; // R6
        if (sec_sel) begin
            alt[upfc_pkg::P_SECONDARY] = (pin_func[6:5] != 2'b00); // R7 R8
        end
        unique case (pin_func[2:0]) // R11
            upfc_pkg::UPFC_MODE_RTS_CTS: begin
                alt[upfc_pkg::P_CTS] = 1'b1;
                alt[upfc_pkg::P_PRIMARY] = 1'b1;
            end
            upfc_pkg::UPFC_MODE_DTR_DSR: begin
                alt[upfc_pkg::P_DTR] = 1'b1;
                alt[upfc_pkg::P_DSR] = 1'b1;
            end
            upfc_pkg::UPFC_MODE_EN_ACT, upfc_pkg::UPFC_MODE_EN_FLOW: begin
                alt[upfc_pkg::P_PRIMARY] = 1'b1; // R8
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        next_tx_break = tx_break;
        next_turnaround = turnaround;
        next_pin_func = pin_func;
        next_pin_dir = pin_dir;
        next_pin_out = pin_out;
        next_flow_mode = flow_mode;
        next_prdata = prdata;
        next_pready = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !addr_ok;
        if (wr_en && addr_ok) begin
            unique case (idx)
                upfc_pkg::IDX_TX_BREAK: next_tx_break = pwdata[15:0];
                upfc_pkg::IDX_TURNAROUND: next_turnaround = pwdata[3:0];
                upfc_pkg::IDX_PIN_FUNC: next_pin_func = pwdata[9:0];
                upfc_pkg::IDX_PIN_DIR: next_pin_dir = pwdata[9:0]; // R13
                upfc_pkg::IDX_PIN_SET: begin
                    next_pin_out = pin_out | (pwdata[9:0] & pin_dir & ~alt); // R14 R15
                end
                upfc_pkg::IDX_UART_CTRL: next_flow_mode = pwdata[2:0];
                default: begin
                end
            endcase
        end
        if (rd_en) begin
            next_prdata = 32'h0000_0000;
            unique case (idx)
                upfc_pkg::IDX_TX_BREAK: next_prdata[15:0] = tx_break;
                upfc_pkg::IDX_TURNAROUND: next_prdata[3:0] = turnaround;
                upfc_pkg::IDX_PIN_FUNC: next_prdata[9:0] = pin_func;
                upfc_pkg::IDX_PIN_DIR: next_prdata[9:0] = pin_dir;
                upfc_pkg::IDX_UART_CTRL: next_prdata[2:0] = flow_mode;
                upfc_pkg::IDX_PIN_STATUS: next_prdata[9:0] = pin_sync;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_break <= upfc_pkg::RST_TX_BREAK;
            turnaround <= upfc_pkg::RST_TURNAROUND;
            pin_func <= upfc_pkg::RST_PIN_FUNC; // R4 R5
            pin_dir <= upfc_pkg::RST_PIN_DIR;
            pin_out <= 10'h000;
            flow_mode <= 3'b000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            tx_break <= next_tx_break;
            turnaround <= next_turnaround;
            pin_func <= next_pin_func;
            pin_dir <= next_pin_dir;
            pin_out <= next_pin_out;
            flow_mode <= next_flow_mode;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Break generator: a write of any value other than all ones restarts it
    logic brk_load;
    logic brk_busy;
    logic brk_done;
    assign brk_load = wr_en && addr_ok && (idx == upfc_pkg::IDX_TX_BREAK)
        && (pwdata[15:0] != upfc_pkg::BREAK_FOREVER);
    upfc_bit_timer #(.LEN_W(16), .BIT_CYC(upfc_pkg::BIT_CYCLES)) u_brk (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(brk_load), // R2
        .len(pwdata[15:0]),
        .busy(brk_busy),
        .done(brk_done)
    );

    // Turn-around: enable stays on while sending and for the delay after
    logic tx_busy_d;
    logic ta_load;
    logic ta_busy;
    assign ta_load = tx_busy_d && !uart.tx_busy;
    upfc_bit_timer #(.LEN_W(4), .BIT_CYC(upfc_pkg::BIT_CYCLES)) u_ta (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(ta_load), // R3
        .len(turnaround),
        .busy(ta_busy),
        .done()
    );

    logic en_act;
    logic en_flow;
    logic pol;
    logic next_tx_pin;
    logic next_tx_hold;
    logic next_rx_accept;
    upfc_pkg::upfc_pins_s next_pins;
    always_comb begin
        en_act = uart.tx_busy || ta_busy || ta_load; // R3
        en_flow = uart.addr_match;
        pol = pin_func[upfc_pkg::F_POLARITY];
        next_tx_pin = !((tx_break == upfc_pkg::BREAK_FOREVER) || brk_busy); // R1 R2
        next_tx_hold = 1'b0;
        next_rx_accept = uart.rx_ready;
        if (flow_mode == 3'b011 || flow_mode == 3'b100) begin
            next_rx_accept = uart.rx_ready && uart.addr_match; // R17
        end
        next_pins.o = pin_out;
        next_pins.oe = pin_dir & ~alt; // R13
        next_pins.o[upfc_pkg::P_RX_TOG] = alt[upfc_pkg::P_RX_TOG] ? uart.rx_pulse
            : pin_out[upfc_pkg::P_RX_TOG];
        next_pins.o[upfc_pkg::P_TX_TOG] = alt[upfc_pkg::P_TX_TOG] ? uart.tx_pulse
            : pin_out[upfc_pkg::P_TX_TOG];
        next_pins.oe[upfc_pkg::P_RX_TOG] = pin_dir[upfc_pkg::P_RX_TOG] | alt[upfc_pkg::P_RX_TOG];
        next_pins.oe[upfc_pkg::P_TX_TOG] = pin_dir[upfc_pkg::P_TX_TOG] | alt[upfc_pkg::P_TX_TOG];
        if (alt[upfc_pkg::P_CLK]) begin
            next_pins.o[upfc_pkg::P_CLK] = uart.clk_out; // R6
            next_pins.oe[upfc_pkg::P_CLK] = 1'b1;
        end
        if (alt[upfc_pkg::P_SECONDARY]) begin
            next_pins.oe[upfc_pkg::P_SECONDARY] = 1'b1;
            next_pins.o[upfc_pkg::P_SECONDARY] = ((pin_func[6:5] == upfc_pkg::UPFC_SEC_EN_ACT)
                ? en_act : en_flow) ~^ pol; // R7 R10
        end
        unique case (pin_func[2:0]) // R11
            upfc_pkg::UPFC_MODE_RTS_CTS: begin
                next_pins.oe[upfc_pkg::P_PRIMARY] = 1'b1;
                next_pins.o[upfc_pkg::P_PRIMARY] = !uart_rts_want;
                next_tx_hold = pin_sync[upfc_pkg::P_CTS];
            end
            upfc_pkg::UPFC_MODE_DTR_DSR: begin
                next_pins.oe[upfc_pkg::P_DTR] = 1'b1;
                next_pins.o[upfc_pkg::P_DTR] = !uart_dtr_want;
                next_tx_hold = pin_sync[upfc_pkg::P_DSR];
            end
            upfc_pkg::UPFC_MODE_EN_ACT, upfc_pkg::UPFC_MODE_EN_FLOW: begin
                if (alt[upfc_pkg::P_PRIMARY]) begin
                    next_pins.oe[upfc_pkg::P_PRIMARY] = 1'b1;
                    next_pins.o[upfc_pkg::P_PRIMARY] =
                        ((pin_func[2:0] == upfc_pkg::UPFC_MODE_EN_ACT) ? en_act : en_flow)
                        ~^ pol; // R8 R10
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_busy_d <= 1'b0;
            tx_pin <= 1'b1;
            tx_hold <= 1'b0;
            rx_accept <= 1'b0;
            pins <= '0;
        end else begin
            tx_busy_d <= uart.tx_busy;
            tx_pin <= next_tx_pin;
            tx_hold <= next_tx_hold;
            rx_accept <= next_rx_accept;
            pins <= next_pins;
        end
    end

    property forever_break_p;
        @(posedge ref_clk) disable iff (rst)
        (tx_break == upfc_pkg::BREAK_FOREVER) |=> !tx_pin;
    endproperty
    continuous_break_a: assert property (forever_break_p) else $error("break not held"); // R1
    zero_break_a: assert property (@(posedge ref_clk) disable iff (rst)
        (tx_break == 16'h0000 && !brk_busy) |=> tx_pin) else $error("spurious break"); // R2
    sequence tx_end_s;
        tx_busy_d && !uart.tx_busy;
    endsequence
    turnaround_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (tx_end_s and (turnaround != 4'h0)) |=> ta_busy) else $error("no turnaround"); // R3
    rx_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
        pin_func[9] |=> ##1 (pins.oe[9] || !$past(pin_func[9]))) else $error("pin 9 idle"); // R4
    set_input_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_en && idx == upfc_pkg::IDX_PIN_SET && !pin_dir[0]) |=> (pin_out[0] == $past(pin_out[0])))
        else $error("set hit input"); // R15
    set_output_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_en && addr_ok && idx == upfc_pkg::IDX_PIN_SET && pwdata[1] && pin_dir[1]
        && !alt[1]) |=> pin_out[1]) else $error("set lost"); // R14
    clk_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        (alt[6] && $stable(alt[6])) |=> pins.oe[6]) else $error("clock not routed"); // R6
    sec_gpio_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pin_func[4] |-> !alt[7]) else $error("pin 7 taken"); // R8
endmodule // upfc_top

// File: upfc_far_side.sv
/*
 * Far-side model: the UART engine status carrier and the peripherals
 * that hang on the ten pins.
 * Assumes the bench sets the engine levels and the idle pin levels.
 */
`timescale 1ns/1ps
module upfc_far_side (
    input wire logic ref_clk,
    input wire logic busy,
    input wire logic match,
    input wire logic ready,
    input wire logic [9:0] ext,
    input wire upfc_pkg::upfc_pins_s pins,
    output upfc_pkg::upfc_uart_s uart,
    output logic [9:0] pin_in
);
    initial uart = '0;
    always @(posedge ref_clk) begin
        uart.tx_busy <= busy;
        uart.addr_match <= match;
        uart.rx_ready <= ready;
        uart.tx_pulse <= 1'($urandom);
        uart.rx_pulse <= 1'($urandom);
        uart.clk_out <= ~uart.clk_out;
    end
    // Pins the block does not drive show the peripheral's level
    assign pin_in = (pins.oe & pins.o) | (~pins.oe & ext);
endmodule // upfc_far_side

// File: uart_pin_function_control_bench.sv
/*
 * Self-checking bench for upfc_top: APB register traffic, pin roles,
 * break timing and turn-around timing against a bench model.
 * Assumes upfc_far_side stands for the engine and the pin peripherals.
 */
`timescale 1ns/1ps
module uart_pin_function_control_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_pin, tx_hold, rx_accept;
    logic busy = 1'b0, match = 1'b0, ready = 1'b0, rts = 1'b0, dtr = 1'b0;
    logic [9:0] ext = 10'h000;
    logic [9:0] pin_in;
    upfc_pkg::upfc_uart_s uart, uart_d;
    upfc_pkg::upfc_pins_s pins;
    int n_errors = 0, tests_run = 0;
    int func = 32'h300, dir = 0, latch = 0, flow = 0;
    localparam int BC = upfc_pkg::BIT_CYCLES;

    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) uart_d <= uart;

    upfc_top upfc_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .uart(uart), .uart_rts_want(rts), .uart_dtr_want(dtr),
        .tx_pin(tx_pin), .tx_hold(tx_hold), .rx_accept(rx_accept), .pins(pins),
        .pin_in(pin_in));
    upfc_far_side upfc_far_side_inst (.ref_clk(ref_clk), .busy(busy), .match(match),
        .ready(ready), .ext(ext), .pins(pins), .uart(uart), .pin_in(pin_in));

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; entered and left just after a rising edge
    task automatic apb(logic wr, logic [11:0] idx, logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) chk("pready", 1, 0);
        @(posedge ref_clk);
    endtask

    task automatic wr(logic [11:0] idx, logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdchk(logic [11:0] idx, logic [31:0] exp, logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        chk($sformatf("read %h", idx), exp, r);
        chk($sformatf("err %h", idx), 32'(exp_err), 32'(e));
    endtask

    // Pins still doing plain I/O under a pin-function value
    function automatic logic [9:0] plain(int f);
        logic [9:0] m = 10'h3ff;
        if (f[9]) m[9] = 1'b0;
        if (f[8]) m[8] = 1'b0;
        if (f[7]) m[6] = 1'b0;
        case (f[2:0])
            1: m[5:4] = 2'b00;
            2: m[3:2] = 2'b00;
            3, 4: m[5] = 1'b0;
            default: ;
        endcase
        if (f[4] && f[6:5] != 0) m[7] = 1'b0;
        return m;
    endfunction

    task automatic set_pins(int d);
        wr(upfc_pkg::IDX_PIN_SET, d);
        latch = latch | (d & dir & int'(plain(func)));
    endtask

    task automatic check_pins(string tn);
        logic [9:0] eo, eoe, m;
        logic ea, em;
        repeat (4) @(posedge ref_clk);
        repeat (3) begin
            @(negedge ref_clk);
            m = plain(func);
            ea = uart_d.tx_busy ~^ func[3];
            em = uart_d.addr_match ~^ func[3];
            eo = latch[9:0];
            // Alternate roles drive except the two handshake inputs
            eoe = (m & dir[9:0]) | (~m & ~10'h018);
            if (func[9]) eo[9] = uart_d.rx_pulse;
            if (func[8]) eo[8] = uart_d.tx_pulse;
            if (func[7]) eo[6] = uart_d.clk_out;
            case (func[2:0])
                1: eo[5] = !rts;
                2: eo[2] = !dtr;
                3: eo[5] = ea;
                4: eo[5] = em;
                default: ;
            endcase
            if (func[4] && func[6:5] == 1) eo[7] = ea;
            if (func[4] && func[6:5] == 2) eo[7] = em;
            chk("pins.oe", eoe, pins.oe);
            chk("pins.o", eo & eoe, pins.o & eoe);
            if (func[2:0] == 1) chk("hold cts", ext[4], tx_hold);
            if (func[2:0] == 2) chk("hold dsr", ext[3], tx_hold);
            chk("rx_accept", uart_d.rx_ready & (flow == 3 || flow == 4 ?
                uart_d.addr_match : 1'b1), rx_accept);
        end
        @(posedge ref_clk);
        $display("test %s done", tn);
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        results();
    end

    initial begin
        int k, md, f, cnt;
        int bl[2] = '{0, 2};
        int tl[3] = '{0, 1, 15};
        void'($urandom(76));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdchk(upfc_pkg::IDX_TX_BREAK, 0, 0);
        rdchk(upfc_pkg::IDX_TURNAROUND, 0, 0);
        rdchk(upfc_pkg::IDX_PIN_FUNC, 32'h300, 0);
        rdchk(upfc_pkg::IDX_PIN_DIR, 0, 0);
        rdchk(upfc_pkg::IDX_PIN_SET, 0, 0);
        rdchk(12'h3ff, 0, 1);
        check_pins("reset");
        f = $urandom & 32'hf;
        wr(upfc_pkg::IDX_TURNAROUND, f);
        rdchk(upfc_pkg::IDX_TURNAROUND, f, 0);
        wr(upfc_pkg::IDX_TURNAROUND, 0);
        for (k = 0; k < 12; k++) begin
            md = $urandom_range(4);
            f = $urandom & 32'h3f8;
            if (f[6:5] == 3) f[6:5] = 2'b10;
            if (f[4] && md == (f[6:5] == 0 ? 0 : f[6:5] + 2)) md = 1;
            func = f | md;
            flow = $urandom_range(4);
            busy <= 1'($urandom);
            match <= 1'($urandom);
            ready <= 1'($urandom);
            rts <= 1'($urandom);
            dtr <= 1'($urandom);
            ext <= 10'($urandom);
            wr(upfc_pkg::IDX_UART_CTRL, flow);
            rdchk(upfc_pkg::IDX_UART_CTRL, flow, 0);
            wr(upfc_pkg::IDX_PIN_FUNC, func);
            rdchk(upfc_pkg::IDX_PIN_FUNC, func, 0);
            set_pins($urandom & 32'h3ff);
            dir = $urandom & 32'h3ff;
            wr(upfc_pkg::IDX_PIN_DIR, dir);
            rdchk(upfc_pkg::IDX_PIN_DIR, dir, 0);
            set_pins($urandom & 32'h3ff);
            check_pins($sformatf("pins %0d", k));
        end
        foreach (bl[j]) begin
            wr(upfc_pkg::IDX_TX_BREAK, bl[j]);
            cnt = 0;
            while (tx_pin === 1'b0 && cnt < 400) begin
                @(posedge ref_clk);
                cnt++;
            end
            chk("break", bl[j] * BC, cnt);
        end
        wr(upfc_pkg::IDX_TX_BREAK, 32'hffff);
        cnt = 0;
        repeat (300) begin
            @(posedge ref_clk);
            if (tx_pin === 1'b0) cnt++;
        end
        chk("break held", 300, cnt);
        wr(upfc_pkg::IDX_TX_BREAK, 0);
        chk("break end", 1, tx_pin);
        $display("test break done");
        func = 32'h30b;
        wr(upfc_pkg::IDX_PIN_FUNC, func);
        foreach (tl[j]) begin
            wr(upfc_pkg::IDX_TURNAROUND, tl[j]);
            busy <= 1'b1;
            repeat (6) @(posedge ref_clk);
            busy <= 1'b0;
            cnt = 0;
            do begin
                @(posedge ref_clk);
                cnt++;
            end while (pins.o[5] === 1'b1 && cnt < 2000);
            // Four cycles of engine, detect and pin register latency
            chk("turnaround", tl[j] * BC, cnt - 4);
        end
        $display("test turnaround done");
        results();
    end
endmodule // uart_pin_function_control_bench
